// ### rtl/eat_ack_term.sv
// External bus acknowledge termination: edge and level modes, time-out
//
// Overview of operation
// - With acknowledge enabled a cycle not ended within 1024 clocks errors.
// - Two modes exist, rising edge and level with an insensitivity delay.
// - Acknowledge applies only to asynchronous cycles, sync bit kept clear.
// - In edge mode a rising acknowledge edge in time ends the transfer.
// - Edge mode is available only on chip select 5.
// - A nonzero assert/negate delay makes back-to-back cycles need new edges.
// - In level mode acknowledge is ignored for 2 to 5 clocks per delay field.
// - High acknowledge after the delay lets the programmed wait states run.
// - Low acknowledge after the delay stalls until high, within the time-out.
// - Acknowledge going low after the insensitivity delay in level mode pauses the transfer.
// - Level mode is usable on every chip select except number 4.
`timescale 1ns/10ps
module eat_ack_term
  import eat_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Internal request
  input wire logic reqValid,
  input wire logic [2:0] reqCs,
  // Per chip select configuration (selected one)
  input wire logic syncMode,
  input wire logic extendedWaitBit,
  input wire logic [5:0] waitStateCount,
  input wire logic [3:0] csAssertDelay,
  input wire logic [3:0] csNegateDelay,
  input wire logic [1:0] ackSampleDelay,
  // Global configuration
  input wire logic ackEdgeEnable,
  // External pin
  input wire logic transferAckIn,
  // Outputs
  output logic busy,
  output logic csActive,
  output logic strobeActive,
  output logic done,
  output logic busError
);
  eat_state_t state_q;
  logic [10:0] toCnt_q;
  logic [5:0] waitCnt_q;
  logic [2:0] insCnt_q;
  logic [3:0] negCnt_q;
  logic busy_q, csActive_q, strobe_q, done_q, err_q;
  logic ackRise;
  logic edgeMode, levelMode, timeout;
  logic abandon, finishWait, endXfer;
  logic [10:0] edgeWait_q;

  eat_rise_detect u_rise (
    .clk(clk),
    .rstn(rstn),
    .level(transferAckIn),
    .rise(ackRise)
  );

  // edge mode or level mode picked from the configuration
  // edge mode only on chip select 5, only asynchronous, enabled globally
  assign edgeMode = ackEdgeEnable && !syncMode && reqCs == EDGE_CS &&
                    waitStateCount == WSC_EDGE;
  // level mode on any select except the shared one
  assign levelMode = !ackEdgeEnable && !syncMode && extendedWaitBit &&
                     reqCs != SHARED_ACK_CS;
  // time-out after 1024 cycles in an acknowledged transfer
  assign timeout = toCnt_q == TIMEOUT_LAST;
  // level cycle given up when time-out hits with acknowledge low
  assign abandon = state_q == ST_WAIT && levelMode && timeout &&
                   !transferAckIn;
  // wait states used up while acknowledge lets the cycle run
  assign finishWait = state_q == ST_WAIT && waitCnt_q == 6'h00 &&
                      (!levelMode || transferAckIn);
  // Transfer ends on this edge in either mode
  assign endXfer = abandon || finishWait ||
                   (state_q == ST_EDGE && (ackRise || timeout));

  // Transfer state machine
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (reqValid) begin
            if (edgeMode) begin
              state_q <= ST_EDGE;
            end else begin
              state_q <= ST_INSENS;
            end
          end
        end
        ST_INSENS: begin
          if (insCnt_q == 3'h1) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (levelMode && timeout && !transferAckIn) begin
            state_q <= ST_NEGATE;
          // high acknowledge lets wait states finish
          end else if (waitCnt_q == 6'h00 &&
                       (!levelMode || transferAckIn)) begin
            state_q <= ST_NEGATE;
          end
        end
        ST_EDGE: begin
          // rising edge ends transfer; time-out abandons it
          if (ackRise || timeout) begin
            state_q <= ST_NEGATE;
          end
        end
        ST_NEGATE: begin
          // negate gap forces a fresh edge before the next cycle
          if (negCnt_q == 4'h0) begin
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Insensitivity counter, 2..5 cycles
  always_ff @(posedge clk) begin
    if (!rstn) begin
      insCnt_q <= 3'h0;
    end else if (state_q == ST_IDLE) begin
      insCnt_q <= SAMPLE_DELAY_MIN + {1'b0, ackSampleDelay};
    end else if (state_q == ST_INSENS) begin
      insCnt_q <= insCnt_q - 3'h1;
    end
  end

  // Wait-state counter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      waitCnt_q <= 6'h00;
    end else if (state_q == ST_IDLE) begin
      waitCnt_q <= waitStateCount;
    // low acknowledge stalls the wait count
    end else if (state_q == ST_WAIT && waitCnt_q != 6'h00 &&
                 (!levelMode || transferAckIn)) begin
      waitCnt_q <= waitCnt_q - 6'h01;
    end
  end

  // Time-out counter, runs only in the edge and wait states
  always_ff @(posedge clk) begin
    if (!rstn) begin
      toCnt_q <= 11'h000;
    end else if (state_q == ST_IDLE) begin
      toCnt_q <= 11'h000;
    end else if ((state_q == ST_EDGE || state_q == ST_WAIT) && !timeout) begin
      toCnt_q <= toCnt_q + 11'h001;
    end
  end

  // Cycles spent in the edge wait, for the bound check only
  always_ff @(posedge clk) begin
    if (!rstn || state_q != ST_EDGE) begin
      edgeWait_q <= 11'h000;
    end else begin
      edgeWait_q <= edgeWait_q + 11'h001;
    end
  end

  // Negate gap counter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      negCnt_q <= 4'h0;
    end else if (state_q == ST_IDLE) begin
      negCnt_q <= (csNegateDelay > csAssertDelay) ? csNegateDelay
                                                  : csAssertDelay;
    end else if (state_q == ST_NEGATE && negCnt_q != 4'h0) begin
      negCnt_q <= negCnt_q - 4'h1;
    end
  end

  // Outputs
  always_ff @(posedge clk) begin
    if (!rstn) begin
      busy_q <= 1'b0;
      csActive_q <= 1'b0;
      strobe_q <= 1'b0;
      done_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      busy_q <= state_q != ST_IDLE || reqValid;
      // select and strobe drop together with done
      csActive_q <= (state_q == ST_IDLE) ? reqValid
                    : (state_q != ST_NEGATE && !endXfer);
      strobe_q <= (state_q == ST_IDLE) ? reqValid
                  : (state_q != ST_NEGATE && !endXfer);
      done_q <= 1'b0;
      err_q <= 1'b0;
      if (state_q == ST_EDGE && (ackRise || timeout)) begin
        done_q <= 1'b1;
        err_q <= timeout && !ackRise;
      end else if (state_q == ST_WAIT) begin
        if (levelMode && timeout && !transferAckIn) begin
          done_q <= 1'b1;
          err_q <= 1'b1;
        end else if (waitCnt_q == 6'h00 && (!levelMode || transferAckIn)) begin
          done_q <= 1'b1;
        end
      end
    end
  end

  assign busy = busy_q;
  assign csActive = csActive_q;
  assign strobeActive = strobe_q;
  assign done = done_q;
  assign busError = err_q;

  // Assertions
  // error comes with done
  a_error_has_done: assert property (
      @(posedge clk) disable iff (!rstn) busError |-> done)
    else $error("error without done");
  a_timeout_error: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_EDGE && timeout && !ackRise) |=> busError)
    else $error("edge time-out not flagged");
  a_edge_done: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_EDGE && ackRise) |=> done && !busError)
    else $error("edge did not end transfer");
  // edge wait only on select 5
  a_edge_only_cs5: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_IDLE && reqValid && reqCs != EDGE_CS) |=>
      state_q != ST_EDGE)
    else $error("edge mode on wrong select");
  a_insens_wait: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_IDLE && reqValid && !edgeMode) |=>
      state_q == ST_INSENS [*2])
    else $error("insensitivity too short");
  // longest setting gives five quiet cycles
  a_insens_long: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_IDLE && reqValid && !edgeMode && ackSampleDelay == 2'h3)
      |=> state_q == ST_INSENS [*5] ##1 state_q == ST_WAIT)
    else $error("insensitivity not five cycles");
  a_level_stall: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_WAIT && levelMode && !transferAckIn && !timeout) |=>
      !done)
    else $error("ended while acknowledge low");
  // wait count frozen in a stall
  a_stall_hold: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_WAIT && levelMode && !transferAckIn && waitCnt_q != 0)
      |=> waitCnt_q == $past(waitCnt_q))
    else $error("wait ran in stall");
  // high acknowledge lets wait states run
  a_wait_count: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_WAIT && levelMode && transferAckIn && waitCnt_q != 0)
      |=> waitCnt_q == $past(waitCnt_q) - 6'h01)
    else $error("wait state not counted");
  a_level_timeout: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_WAIT && levelMode && timeout && !transferAckIn) |=>
      busError)
    else $error("level time-out not flagged");
  a_error_cause: assert property (
      @(posedge clk) disable iff (!rstn) busError |-> $past(timeout))
    else $error("error without time-out");
  a_timeout_bound: assert property (
      @(posedge clk) disable iff (!rstn) toCnt_q <= TIMEOUT_LAST)
    else $error("time-out counter overrun");
  // edge wait never outlasts the window
  a_edge_bounded: assert property (
      @(posedge clk) disable iff (!rstn) edgeWait_q <= TIMEOUT_CYCLES)
    else $error("edge wait too long");
  a_done_pulse: assert property (
      @(posedge clk) disable iff (!rstn) done |=> !done)
    else $error("done held too long");
  a_negate_after: assert property (
      @(posedge clk) disable iff (!rstn) busError |-> !strobeActive)
    else $error("strobe held on error");
  a_cs_released: assert property (
      @(posedge clk) disable iff (!rstn) done |-> !csActive)
    else $error("select held at end");
  a_gap_kept: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_NEGATE && negCnt_q != 0) |=> state_q == ST_NEGATE)
    else $error("negate gap cut short");
  // synchronous cycles never wait on an edge
  a_sync_no_edge: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_IDLE && reqValid && syncMode) |=> state_q != ST_EDGE)
    else $error("edge mode in sync cycle");
  a_shared_cs_plain: assert property (
      @(posedge clk) disable iff (!rstn)
      (state_q == ST_WAIT && reqCs == SHARED_ACK_CS && waitCnt_q == 6'h00)
      |=> done && !busError)
    else $error("shared select stalled");
  c_edge_end: cover property (@(posedge clk) state_q == ST_EDGE && ackRise);
  c_level_stall: cover property (@(posedge clk)
    state_q == ST_WAIT && levelMode && !transferAckIn);
  c_timeout: cover property (@(posedge clk) busError);
endmodule : eat_ack_term

// ### rtl/eat_pkg.sv
// Package: constants for the external bus acknowledge termination block
package eat_pkg;
  // Time-out window in system clock cycles
  localparam int unsigned TIMEOUT_CYCLES = 1024;
  localparam logic [10:0] TIMEOUT_LAST = 11'h03FF;
  // Chip select numbering
  localparam int unsigned NUM_CS = 6;
  localparam logic [2:0] EDGE_CS = 3'h5;
  localparam logic [2:0] SHARED_ACK_CS = 3'h4;
  // Insensitivity interval: code 0..3 maps to 2..5 cycles
  localparam logic [2:0] SAMPLE_DELAY_MIN = 3'h2;
  // Wait-state field width and the edge-mode marker value
  localparam int unsigned WSC_W = 6;
  localparam logic [5:0] WSC_EDGE = 6'h3F;
  localparam logic [5:0] WSC_LEVEL_MIN = 6'h02;
  localparam logic [3:0] CSN_LEVEL_MAX = 4'h2;
  // Transfer state machine
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_INSENS = 3'b001,
    ST_WAIT = 3'b010,
    ST_EDGE = 3'b011,
    ST_NEGATE = 3'b100
  } eat_state_t;
endpackage : eat_pkg

// ### rtl/eat_rise_detect.sv
// Rising edge detector on a synchronous level input
`timescale 1ns/10ps
module eat_rise_detect (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Level in, edge out
  input wire logic level,
  output logic rise
);
  logic prev_q;

  // Previous level
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= level;
    end
  end

  // Low to high transition
  assign rise = level & ~prev_q;
endmodule : eat_rise_detect

// ### testbench/eat_periph_model.sv
// Partner model: external peripheral driving the acknowledge pin
`timescale 1ns/10ps
module eat_periph_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus side
  input wire logic csActive,
  output logic transferAckIn,
  // Behaviour: 0 high, 1 late, 2 never, 3 sticky high
  input wire logic [1:0] ackMode,
  input wire logic [10:0] ackLatency
);
  logic [10:0] cnt_q;
  logic stuck_q;
  // Cycles since chip select went active
  always_ff @(posedge clk) begin
    if (!rstn || !csActive) begin
      cnt_q <= 11'h000;
    end else if (cnt_q != 11'h7FF) begin
      cnt_q <= cnt_q + 11'h001;
    end
  end
  // Sticky level: no fresh edge on the next cycle
  always_ff @(posedge clk) begin
    if (!rstn || ackMode != 2'h3) begin
      stuck_q <= 1'b0;
    end else if (csActive && cnt_q >= ackLatency) begin
      stuck_q <= 1'b1;
    end
  end
  always_comb begin
    case (ackMode)
      2'h0: transferAckIn = 1'b1;
      2'h1: transferAckIn = !csActive || cnt_q >= ackLatency;
      2'h2: transferAckIn = !csActive;
      default: transferAckIn = stuck_q || (csActive && cnt_q >= ackLatency);
    endcase
  end
endmodule : eat_periph_model

// ### testbench/tb_eat_ack_term.sv
// Testbench for the acknowledge termination block
`timescale 1ns/10ps
module tb_eat_ack_term
  import eat_pkg::*;
;
  logic clk, rstn, reqValid, syncMode, extendedWaitBit, ackEdgeEnable;
  logic [2:0] reqCs;
  logic [5:0] waitStateCount;
  logic [3:0] csAssertDelay, csNegateDelay;
  logic [1:0] ackSampleDelay, ackMode;
  logic [10:0] ackLatency;
  logic transferAckIn, busy, csActive, strobeActive, done, busError;
  logic gotErr;
  int n_fail = 0;
  int total_checks = 0;
  int cyc, prevCyc, g;

  eat_ack_term dut_u (.clk(clk), .rstn(rstn), .reqValid(reqValid),
    .reqCs(reqCs), .syncMode(syncMode), .extendedWaitBit(extendedWaitBit),
    .waitStateCount(waitStateCount), .csAssertDelay(csAssertDelay),
    .csNegateDelay(csNegateDelay), .ackSampleDelay(ackSampleDelay),
    .ackEdgeEnable(ackEdgeEnable), .transferAckIn(transferAckIn),
    .busy(busy), .csActive(csActive), .strobeActive(strobeActive),
    .done(done), .busError(busError));
  eat_periph_model peer_u (.clk(clk), .rstn(rstn), .csActive(csActive),
    .transferAckIn(transferAckIn), .ackMode(ackMode),
    .ackLatency(ackLatency));

  // Clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : check

  task finish_test;
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task cfg(input logic [2:0] cs, input logic [5:0] wait_state_count, input logic edg,
           input logic ew, input logic [1:0] dly, input logic [1:0] md,
           input logic [10:0] lat);
    reqCs = cs;
    waitStateCount = wait_state_count;
    ackEdgeEnable = edg;
    extendedWaitBit = ew;
    ackSampleDelay = dly;
    ackMode = md;
    ackLatency = lat;
  endtask : cfg

  // One transfer; cyc counts edges from take to done
  task xfer;
    reqValid = 1'b1;
    @(posedge clk) #2 reqValid = 1'b0;
    cyc = 1;
    while (done !== 1'b1 && cyc < 1500) begin
      @(posedge clk) #2 cyc++;
    end
    gotErr = busError;
    check(done === 1'b1 && strobeActive === 1'b0, "done or strobe");
    check(csActive === 1'b0, "select held");
    g = 0;
    while (busy !== 1'b0 && g < 40) begin
      @(posedge clk) #2 g++;
    end
    check(busy === 1'b0, "busy held");
  endtask : xfer

  // Watchdog
  initial begin
    #(20000 * 25);
    n_fail++;
    finish_test();
  end

  initial begin
    rstn = 1'b0;
    reqValid = 1'b0;
    syncMode = 1'b0;
    csAssertDelay = 4'h1;
    csNegateDelay = 4'h1;
    cfg(3'h1, 6'h02, 1'b0, 1'b1, 2'h0, 2'h0, 11'h000);
    repeat (12) @(posedge clk);
    #2 rstn = 1'b0;
    @(posedge clk) #2 rstn = 1'b1;
    check(busy === 1'b0 && done === 1'b0, "reset outputs");
    for (int d = 0; d < 4; d++) begin
      cfg(3'h1, 6'h02, 1'b0, 1'b1, d[1:0], 2'h0, 11'h000);
      xfer();
      check(gotErr === 1'b0 && cyc >= d + 4 && cyc <= d + 8, "lvl");
      if (d > 0) check(cyc == prevCyc + 1, "delay step");
      prevCyc = cyc;
    end
    cfg(3'h2, 6'h02, 1'b0, 1'b1, 2'h0, 2'h1, 11'h028);
    xfer();
    check(gotErr === 1'b0 && cyc >= 40 && cyc <= 52, "stall");
    cfg(3'h0, 6'h02, 1'b0, 1'b1, 2'h0, 2'h2, 11'h000);
    xfer();
    check(gotErr === 1'b1 && cyc >= 1024 && cyc <= 1030, "lvl tmo");
    cfg(3'h5, WSC_EDGE, 1'b1, 1'b0, 2'h0, 2'h1, 11'h00A);
    xfer();
    check(gotErr === 1'b0 && cyc >= 10 && cyc <= 15, "edge");
    ackMode = 2'h2;
    xfer();
    check(gotErr === 1'b1 && cyc >= 1024 && cyc <= 1030, "edg tmo");
    cfg(3'h5, WSC_EDGE, 1'b1, 1'b0, 2'h0, 2'h3, 11'h005);
    xfer();
    check(gotErr === 1'b0, "first edge");
    xfer();
    check(gotErr === 1'b1, "stale edge taken");
    cfg(3'h3, WSC_EDGE, 1'b1, 1'b0, 2'h0, 2'h2, 11'h000);
    for (int k = 0; k < 2; k++) begin
      reqCs = k ? 3'h5 : 3'h3;
      syncMode = k[0];
      xfer();
      check(gotErr === 1'b0 && cyc >= 63 && cyc <= 75, "no edge");
    end
    syncMode = 1'b0;
    cfg(3'h4, 6'h02, 1'b0, 1'b1, 2'h0, 2'h2, 11'h000);
    xfer();
    check(gotErr === 1'b0 && cyc <= 10, "cs4 ack used");
    finish_test();
  end
endmodule : tb_eat_ack_term
